// *** verilog/nfd_pkg.sv ***
// constants for the peripheral and flag instruction decoder
package nfd_pkg;
  // system clock and serial bit timing
  localparam int CLK_FREQ_MHZ = 20;
  localparam int SER_BIT_NS = 1000;
  localparam int SER_BIT_CYCLES = (SER_BIT_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int SER_CNT_W = 5;

  // register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ENABLES = 4'h4;
  localparam logic [3:0] REG_EVENTS = 4'h8;
  localparam logic [3:0] REG_PRELOAD = 4'hC;

  // field positions
  localparam int CTRL_DEC_EN_BIT = 0;
  localparam int EN_HOLD_LSB = 0;
  localparam int EN_IRQ_LSB = 8;
  localparam int EN_STOP_LSB = 16;
  localparam int EN_PCHG_LSB = 24;
  localparam int EN_P1_LSB = 28;
  localparam int EN_RD_HOLD_BIT = 30;
  localparam int EN_GIE_BIT = 31;
  localparam int EV_LATCH_LSB = 0;
  localparam int EV_PSTAT_LSB = 8;
  localparam int EV_RD_BIT = 20;
  localparam int PL_TA_LSB = 0;
  localparam int PL_TB_LSB = 8;
  localparam int PL_LCD_LSB = 16;

  // reset values
  localparam logic CTRL_DEC_EN_RST = 1'b1;
  localparam logic [7:0] FLAGS8_RST = 8'h00;
  localparam logic [3:0] NIB_RST = 4'h0;

  // opcode masks
  localparam logic [15:0] M_BYTE = 16'hFF00;
  localparam logic [15:0] M_R = 16'hFF80;
  localparam logic [15:0] M_NIB = 16'hFFF0;
  localparam logic [15:0] M_BIT = 16'hFFFE;
  localparam logic [15:0] M_FULL = 16'hFFFF;

  // opcode values
  localparam logic [15:0] OP_HOLD_EN = 16'h4100;
  localparam logic [15:0] OP_RD_HOLD_EN = 16'h3100;
  localparam logic [15:0] OP_IRQ_EN = 16'h5100;
  localparam logic [15:0] OP_PCHG_EN = 16'h4300;
  localparam logic [15:0] OP_P1_EN = 16'h3300;
  localparam logic [15:0] OP_STOP_EN = 16'h5200;
  localparam logic [15:0] OP_EV_CLR = 16'h4000;
  localparam logic [15:0] OP_RD_EV_CLR = 16'h3000;
  localparam logic [15:0] OP_PST0_CLR = 16'h4200;
  localparam logic [15:0] OP_PST1_CLR = 16'h4280;
  localparam logic [15:0] OP_PST2_CLR = 16'h42C0;
  localparam logic [15:0] OP_MDIV_CLR = 16'h1700;
  localparam logic [15:0] OP_SDIV_CLR = 16'h5580;
  localparam logic [15:0] OP_WDT_CLR = 16'h1780;
  localparam logic [15:0] OP_SER_OUT = 16'hAF00;
  localparam logic [15:0] OP_SHR = 16'h4D00;
  localparam logic [15:0] OP_RRC = 16'h4D80;
  localparam logic [15:0] OP_SHL = 16'h4C00;
  localparam logic [15:0] OP_RLC = 16'h4C80;
  localparam logic [15:0] OP_LCD_PL = 16'h9800;
  localparam logic [15:0] OP_LCD_PH = 16'h9880;
  localparam logic [15:0] OP_LCD_WR = 16'h9A00;
  localparam logic [15:0] OP_EV_LO = 16'h5D00;
  localparam logic [15:0] OP_EV_HI = 16'h5D80;
  localparam logic [15:0] OP_TA_WL = 16'hAA00;
  localparam logic [15:0] OP_TA_WH = 16'hAA80;
  localparam logic [15:0] OP_TB_WL = 16'hAB00;
  localparam logic [15:0] OP_TB_WH = 16'hAB80;
  localparam logic [15:0] OP_TA_RL = 16'h8F00;
  localparam logic [15:0] OP_TA_RH = 16'h8F80;
  localparam logic [15:0] OP_TB_RL = 16'h9900;
  localparam logic [15:0] OP_TB_RH = 16'h9980;
  localparam logic [15:0] OP_INT_EN = 16'h50C0;
  localparam logic [15:0] OP_INT_DIS = 16'h5080;
  localparam logic [15:0] OP_HOLD = 16'h0080;
  localparam logic [15:0] OP_STOP = 16'h00C0;

  // shift kinds
  typedef enum logic [1:0] {
    NFD_SH_RIGHT = 2'h0,
    NFD_ROT_RIGHT = 2'h1,
    NFD_SH_LEFT = 2'h2,
    NFD_ROT_LEFT = 2'h3
  } nfd_shift_t;
endpackage

// *** verilog/nfd_ser_if.sv ***
// link between decoder and the serial shift-out unit
`timescale 1ns/1ns
interface nfd_ser_if;
  logic load;
  logic [7:0] data;
  logic busy;
  logic pin;
  logic oe;
  modport ctl (output load, output data, input busy, input pin, input oe);
  modport unit (input load, input data, output busy, output pin, output oe);
endinterface

// *** verilog/nfd_ser_shift.sv ***
// serial shift-out of one byte on port pin P0.1, msb first
`timescale 1ns/1ns
module nfd_ser_shift (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  nfd_ser_if.unit ser
);
  typedef enum logic {NFD_SS_IDLE = 1'b0, NFD_SS_SHIFT = 1'b1} nfd_ser_state_t;
  localparam logic [SER_CNT_W-1:0] BIT_LAST = SER_CNT_W'(nfd_pkg::SER_BIT_CYCLES - 1);
  localparam int SER_CNT_W = nfd_pkg::SER_CNT_W;

  nfd_ser_state_t state_reg, state_next;
  logic [7:0] sh_reg, sh_next;
  logic [SER_CNT_W-1:0] cnt_reg, cnt_next;
  logic [2:0] bit_reg, bit_next;
  logic pin_reg, pin_next;

  always_comb begin
    state_next = state_reg;
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    pin_next = pin_reg;
    unique case (state_reg)
      NFD_SS_IDLE: begin
        if (ser.load) begin
          state_next = NFD_SS_SHIFT;
          sh_next = ser.data;
          pin_next = ser.data[7];
          cnt_next = '0;
          bit_next = 3'h0;
        end
      end
      NFD_SS_SHIFT: begin
        // bit-rate enable: one pulse every SER_BIT_CYCLES clocks
        if (cnt_reg == BIT_LAST) begin
          cnt_next = '0;
          if (bit_reg == 3'h7) begin
            state_next = NFD_SS_IDLE;
            pin_next = 1'b0;
          end else begin
            bit_next = bit_reg + 3'h1;
            sh_next = {sh_reg[6:0], 1'b0};
            pin_next = sh_reg[6];
          end
        end else begin
          cnt_next = cnt_reg + SER_CNT_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= NFD_SS_IDLE;
      sh_reg <= 8'h00;
      cnt_reg <= '0;
      bit_reg <= 3'h0;
      pin_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      pin_reg <= pin_next;
    end
  end

  assign ser.busy = (state_reg == NFD_SS_SHIFT);
  assign ser.oe = (state_reg == NFD_SS_SHIFT);
  assign ser.pin = pin_reg;

  chk_ser_start_bit: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see [RULE11]
    (!ser.busy && ser.load) |=> (ser.busy && ser.pin == $past(ser.data[7])))
    else $error("serial out did not start with msb");
endmodule

// *** verilog/nfd_top.sv ***
// peripheral and flag instruction decoder of the 4-bit core
// Behaviour
// [RULE1] hold-enable opcode loads eight hold release flags
// [RULE2] rd hold-enable opcode sets flag from bit0
// [RULE3] irq-enable opcode loads eight source enables
// [RULE4] port-change enable opcode loads four flags
// [RULE5] port1 enable takes immediate bits 3:2
// [RULE6] stop-wake opcode loads eight wake enables
// [RULE7] event clear clears flags with immediate one
// [RULE8] fixed opcode clears rd event latch
// [RULE9] three fixed opcodes clear port status 0-2
// [RULE10] divider clear opcodes pulse last-stage resets
// [RULE11] serial out shifts ram:acc byte on P0.1
// [RULE12] rotate right through carry, write acc, nibble
// [RULE13] rotate left through carry, write acc, nibble
// [RULE14] shift right logical, zero fill, flags updated
// [RULE15] shift left logical, zero fill, carry updated
// [RULE16] lcd write to pointer high*16 plus low
// [RULE17] event low/high half copied to acc, nibble
// [RULE18] every decoded opcode finishes in one cycle; serial out keeps shifting P0.1 for eight bit times
// [RULE19] timer moves write/read preload nibble halves; reads copy i_timer_a_value/i_timer_b_value halves to ram instead
// [RULE20] int enable/disable gate, hold/stop requests
// [RULE21] watchdog clear pulse, nothing else changes
//
// Implementation choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ns
module nfd_top (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_instr_valid,
  input wire logic [15:0] i_instr,
  input wire logic [3:0] i_ram_nibble,
  input wire logic [3:0] i_acc,
  input wire logic i_carry,
  input wire logic [7:0] i_event_set,
  input wire logic i_rd_event_set,
  input wire logic [11:0] i_port_change_set,
  input wire logic [7:0] i_timer_a_value,
  input wire logic [7:0] i_timer_b_value,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_acc_we,
  output logic [3:0] o_acc_data,
  output logic o_ram_we,
  output logic [3:0] o_ram_data,
  output logic o_carry_we,
  output logic o_carry,
  output logic o_zero_we,
  output logic o_zero,
  output logic o_lcd_we,
  output logic [7:0] o_lcd_addr,
  output logic [3:0] o_lcd_data,
  output logic o_main_div_clr,
  output logic o_sub_div_clr,
  output logic o_wdt_clr,
  output logic o_hold_req,
  output logic o_stop_req,
  output logic o_gie,
  output logic [7:0] o_hold_release_enable,
  output logic o_rd_hold_release_enable,
  output logic [7:0] o_irq_source_enable,
  output logic [3:0] o_port_change_enable,
  output logic [1:0] o_port1_pin_enable,
  output logic [7:0] o_stop_wake_enable,
  output logic [7:0] o_event_latch,
  output logic o_rd_event_latch,
  output logic [11:0] o_port_change_status,
  output logic [7:0] o_timer_a_preload,
  output logic [7:0] o_timer_b_preload,
  output logic o_p01_out,
  output logic o_p01_oe
);
  function automatic logic op_is(input logic [15:0] w, input logic [15:0] m,
                                 input logic [15:0] v);
    return (w & m) == v;
  endfunction

  // returns {carry, nibble}
  function automatic logic [4:0] shift_nib(input nfd_pkg::nfd_shift_t k, input logic [3:0] d,
                                           input logic c);
    logic [4:0] r;
    r = 5'h00;
    unique case (k)
      nfd_pkg::NFD_SH_RIGHT: r = {d[0], 1'b0, d[3:1]};
      nfd_pkg::NFD_ROT_RIGHT: r = {d[0], c, d[3:1]};
      nfd_pkg::NFD_SH_LEFT: r = {d[3], d[2:0], 1'b0};
      nfd_pkg::NFD_ROT_LEFT: r = {d[3], d[2:0], c};
    endcase
    return r;
  endfunction

  nfd_ser_if ser ();
  nfd_ser_shift u_ser (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .ser(ser)
  );

  logic dec_en_reg, dec_en_next;
  logic [7:0] hold_reg, hold_next, irq_reg, irq_next, stop_reg, stop_next;
  logic [7:0] ev_reg, ev_next, ta_reg, ta_next, tb_reg, tb_next;
  logic [3:0] pchg_reg, pchg_next, lpl_reg, lpl_next, lph_reg, lph_next;
  logic [1:0] p1_reg, p1_next;
  logic rd_hold_reg, rd_hold_next, rd_ev_reg, rd_ev_next, gie_reg, gie_next;
  logic [11:0] pst_reg, pst_next;
  logic acc_we_next, ram_we_next, cf_we_next, cf_next, zf_we_next, zf_next;
  logic [3:0] res_next, lcd_data_next;
  logic lcd_we_next, mdiv_next, sdiv_next, wdt_next, hreq_next, sreq_next;
  logic ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [4:0] sh_res;
  logic [7:0] imm;
  logic go;

  assign go = i_instr_valid && dec_en_reg;
  assign imm = i_instr[7:0];

  always_comb begin
    hold_next = hold_reg;
    rd_hold_next = rd_hold_reg;
    irq_next = irq_reg;
    pchg_next = pchg_reg;
    p1_next = p1_reg;
    stop_next = stop_reg;
    ev_next = ev_reg;
    rd_ev_next = rd_ev_reg;
    pst_next = pst_reg;
    ta_next = ta_reg;
    tb_next = tb_reg;
    lpl_next = lpl_reg;
    lph_next = lph_reg;
    gie_next = gie_reg;
    acc_we_next = 1'b0;
    ram_we_next = 1'b0;
    cf_we_next = 1'b0;
    cf_next = o_carry;
    zf_we_next = 1'b0;
    zf_next = o_zero;
    res_next = o_acc_data;
    lcd_we_next = 1'b0;
    lcd_data_next = o_lcd_data;
    mdiv_next = 1'b0;
    sdiv_next = 1'b0;
    wdt_next = 1'b0;
    hreq_next = 1'b0;
    sreq_next = 1'b0;
    sh_res = 5'h00;
    // every opcode but serial out resolves in this single decode cycle; see [RULE18]
    if (go) begin
      if (op_is(i_instr, nfd_pkg::M_BYTE, nfd_pkg::OP_HOLD_EN)) hold_next = imm; // see [RULE1]
      if (op_is(i_instr, nfd_pkg::M_BIT, nfd_pkg::OP_RD_HOLD_EN)) begin
        rd_hold_next = i_instr[0]; // see [RULE2]
      end
      if (op_is(i_instr, nfd_pkg::M_BYTE, nfd_pkg::OP_IRQ_EN)) irq_next = imm; // see [RULE3]
      if (op_is(i_instr, nfd_pkg::M_NIB, nfd_pkg::OP_PCHG_EN)) pchg_next = imm[3:0]; // see [RULE4]
      if (op_is(i_instr, nfd_pkg::M_NIB, nfd_pkg::OP_P1_EN)) p1_next = imm[3:2]; // see [RULE5]
      if (op_is(i_instr, nfd_pkg::M_BYTE, nfd_pkg::OP_STOP_EN)) stop_next = imm; // see [RULE6]
      if (op_is(i_instr, nfd_pkg::M_BYTE, nfd_pkg::OP_EV_CLR)) ev_next = ev_reg & ~imm; // see [RULE7]
      if (op_is(i_instr, nfd_pkg::M_FULL, nfd_pkg::OP_RD_EV_CLR)) rd_ev_next = 1'b0; // see [RULE8]
      if (op_is(i_instr, nfd_pkg::M_FULL, nfd_pkg::OP_PST0_CLR)) pst_next[3:0] = 4'h0; // see [RULE9]
      if (op_is(i_instr, nfd_pkg::M_FULL, nfd_pkg::OP_PST1_CLR)) pst_next[7:4] = 4'h0; // see [RULE9]
      if (op_is(i_instr, nfd_pkg::M_FULL, nfd_pkg::OP_PST2_CLR)) pst_next[11:8] = 4'h0; // see [RULE9]
      mdiv_next = op_is(i_instr, nfd_pkg::M_FULL, nfd_pkg::OP_MDIV_CLR); // see [RULE10]
      sdiv_next = op_is(i_instr, nfd_pkg::M_FULL, nfd_pkg::OP_SDIV_CLR); // see [RULE10]
      wdt_next = op_is(i_instr, nfd_pkg::M_FULL, nfd_pkg::OP_WDT_CLR); // see [RULE21]
      hreq_next = op_is(i_instr, nfd_pkg::M_FULL, nfd_pkg::OP_HOLD); // see [RULE20]
      sreq_next = op_is(i_instr, nfd_pkg::M_FULL, nfd_pkg::OP_STOP); // see [RULE20]
      if (op_is(i_instr, nfd_pkg::M_FULL, nfd_pkg::OP_INT_EN)) gie_next = 1'b1; // see [RULE20]
      if (op_is(i_instr, nfd_pkg::M_FULL, nfd_pkg::OP_INT_DIS)) gie_next = 1'b0; // see [RULE20]
      if (i_instr[15:9] == nfd_pkg::OP_SHL[15:9]) begin
        // opcode bits 8:7 select the kind: 00 shl, 01 rlc, 10 shr, 11 rrc
        sh_res = shift_nib(nfd_pkg::nfd_shift_t'({~i_instr[8], i_instr[7]}),
                           i_ram_nibble, i_carry); // see [RULE12] [RULE13] [RULE14] [RULE15]
        res_next = sh_res[3:0];
        acc_we_next = 1'b1;
        ram_we_next = 1'b1;
        cf_we_next = 1'b1;
        cf_next = sh_res[4];
        zf_we_next = 1'b1;
        zf_next = (sh_res[3:0] == 4'h0);
      end
      if (op_is(i_instr, nfd_pkg::M_R, nfd_pkg::OP_LCD_PL)) lpl_next = i_ram_nibble;
      if (op_is(i_instr, nfd_pkg::M_R, nfd_pkg::OP_LCD_PH)) lph_next = i_ram_nibble;
      if (op_is(i_instr, nfd_pkg::M_R, nfd_pkg::OP_LCD_WR)) begin
        lcd_we_next = 1'b1; // see [RULE16]
        lcd_data_next = i_ram_nibble;
      end
      if (i_instr[15:8] == nfd_pkg::OP_EV_LO[15:8]) begin
        res_next = i_instr[7] ? ev_reg[7:4] : ev_reg[3:0]; // see [RULE17]
        acc_we_next = 1'b1;
        ram_we_next = 1'b1;
      end
      if (op_is(i_instr, nfd_pkg::M_R, nfd_pkg::OP_TA_WL)) ta_next[3:0] = i_ram_nibble; // see [RULE19]
      if (op_is(i_instr, nfd_pkg::M_R, nfd_pkg::OP_TA_WH)) ta_next[7:4] = i_ram_nibble; // see [RULE19]
      if (op_is(i_instr, nfd_pkg::M_R, nfd_pkg::OP_TB_WL)) tb_next[3:0] = i_ram_nibble; // see [RULE19]
      if (op_is(i_instr, nfd_pkg::M_R, nfd_pkg::OP_TB_WH)) tb_next[7:4] = i_ram_nibble; // see [RULE19]
      if (op_is(i_instr, nfd_pkg::M_R, nfd_pkg::OP_TA_RL) ||
          op_is(i_instr, nfd_pkg::M_R, nfd_pkg::OP_TA_RH) ||
          op_is(i_instr, nfd_pkg::M_R, nfd_pkg::OP_TB_RL) ||
          op_is(i_instr, nfd_pkg::M_R, nfd_pkg::OP_TB_RH)) begin
        // bit 12 picks timer b, bit 7 the high half; see [RULE19]
        res_next = i_instr[12] ? (i_instr[7] ? i_timer_b_value[7:4] : i_timer_b_value[3:0])
                               : (i_instr[7] ? i_timer_a_value[7:4] : i_timer_a_value[3:0]);
        ram_we_next = 1'b1;
      end
    end
    // a hardware event in the clearing cycle survives the clear
    ev_next = ev_next | i_event_set; // see [RULE7]
    rd_ev_next = rd_ev_next | i_rd_event_set; // see [RULE8]
    pst_next = pst_next | i_port_change_set; // see [RULE9]
  end

  // serial out accepted only while idle; a second request while busy is dropped
  assign ser.load = go && op_is(i_instr, nfd_pkg::M_R, nfd_pkg::OP_SER_OUT) && !ser.busy; // see [RULE11]
  assign ser.data = {i_ram_nibble, i_acc}; // see [RULE11]

  // avalon slave: one wait cycle per access, read data registered
  always_comb begin
    ack_next = (i_avs_read || i_avs_write) && !ack_reg;
    rdata_next = rdata_reg;
    dec_en_next = dec_en_reg;
    if (i_avs_read && !ack_reg) begin
      rdata_next = 32'h0000_0000;
      unique case (i_avs_address)
        nfd_pkg::REG_CTRL: rdata_next[nfd_pkg::CTRL_DEC_EN_BIT] = dec_en_reg;
        nfd_pkg::REG_ENABLES: begin
          rdata_next[nfd_pkg::EN_HOLD_LSB +: 8] = hold_reg;
          rdata_next[nfd_pkg::EN_IRQ_LSB +: 8] = irq_reg;
          rdata_next[nfd_pkg::EN_STOP_LSB +: 8] = stop_reg;
          rdata_next[nfd_pkg::EN_PCHG_LSB +: 4] = pchg_reg;
          rdata_next[nfd_pkg::EN_P1_LSB +: 2] = p1_reg;
          rdata_next[nfd_pkg::EN_RD_HOLD_BIT] = rd_hold_reg;
          rdata_next[nfd_pkg::EN_GIE_BIT] = gie_reg;
        end
        nfd_pkg::REG_EVENTS: begin
          rdata_next[nfd_pkg::EV_LATCH_LSB +: 8] = ev_reg;
          rdata_next[nfd_pkg::EV_PSTAT_LSB +: 12] = pst_reg;
          rdata_next[nfd_pkg::EV_RD_BIT] = rd_ev_reg;
        end
        nfd_pkg::REG_PRELOAD: begin
          rdata_next[nfd_pkg::PL_TA_LSB +: 8] = ta_reg;
          rdata_next[nfd_pkg::PL_TB_LSB +: 8] = tb_reg;
          rdata_next[nfd_pkg::PL_LCD_LSB +: 8] = {lph_reg, lpl_reg};
        end
        default: rdata_next = 32'h0000_0000;
      endcase
    end
    if (i_avs_write && ack_reg && i_avs_address == nfd_pkg::REG_CTRL && i_avs_byteenable[0]) begin
      dec_en_next = i_avs_writedata[nfd_pkg::CTRL_DEC_EN_BIT];
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      dec_en_reg <= nfd_pkg::CTRL_DEC_EN_RST;
      hold_reg <= nfd_pkg::FLAGS8_RST;
      irq_reg <= nfd_pkg::FLAGS8_RST;
      stop_reg <= nfd_pkg::FLAGS8_RST;
      ev_reg <= nfd_pkg::FLAGS8_RST;
      ta_reg <= nfd_pkg::FLAGS8_RST;
      tb_reg <= nfd_pkg::FLAGS8_RST;
      pchg_reg <= nfd_pkg::NIB_RST;
      lpl_reg <= nfd_pkg::NIB_RST;
      lph_reg <= nfd_pkg::NIB_RST;
      p1_reg <= 2'h0;
      rd_hold_reg <= 1'b0;
      rd_ev_reg <= 1'b0;
      gie_reg <= 1'b0;
      pst_reg <= 12'h000;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      o_acc_we <= 1'b0;
      o_ram_we <= 1'b0;
      o_acc_data <= 4'h0;
      o_ram_data <= 4'h0;
      o_carry_we <= 1'b0;
      o_carry <= 1'b0;
      o_zero_we <= 1'b0;
      o_zero <= 1'b0;
      o_lcd_we <= 1'b0;
      o_lcd_addr <= 8'h00;
      o_lcd_data <= 4'h0;
      o_main_div_clr <= 1'b0;
      o_sub_div_clr <= 1'b0;
      o_wdt_clr <= 1'b0;
      o_hold_req <= 1'b0;
      o_stop_req <= 1'b0;
    end else begin
      dec_en_reg <= dec_en_next;
      hold_reg <= hold_next;
      irq_reg <= irq_next;
      stop_reg <= stop_next;
      ev_reg <= ev_next;
      ta_reg <= ta_next;
      tb_reg <= tb_next;
      pchg_reg <= pchg_next;
      lpl_reg <= lpl_next;
      lph_reg <= lph_next;
      p1_reg <= p1_next;
      rd_hold_reg <= rd_hold_next;
      rd_ev_reg <= rd_ev_next;
      gie_reg <= gie_next;
      pst_reg <= pst_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      o_acc_we <= acc_we_next;
      o_ram_we <= ram_we_next;
      o_acc_data <= res_next;
      o_ram_data <= res_next;
      o_carry_we <= cf_we_next;
      o_carry <= cf_next;
      o_zero_we <= zf_we_next;
      o_zero <= zf_next;
      o_lcd_we <= lcd_we_next;
      o_lcd_addr <= {lph_reg, lpl_reg}; // see [RULE16]
      o_lcd_data <= lcd_data_next;
      o_main_div_clr <= mdiv_next;
      o_sub_div_clr <= sdiv_next;
      o_wdt_clr <= wdt_next;
      o_hold_req <= hreq_next;
      o_stop_req <= sreq_next;
    end
  end

  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_reg;
  assign o_avs_readdata = rdata_reg;
  assign o_gie = gie_reg;
  assign o_hold_release_enable = hold_reg;
  assign o_rd_hold_release_enable = rd_hold_reg;
  assign o_irq_source_enable = irq_reg;
  assign o_port_change_enable = pchg_reg;
  assign o_port1_pin_enable = p1_reg;
  assign o_stop_wake_enable = stop_reg;
  assign o_event_latch = ev_reg;
  assign o_rd_event_latch = rd_ev_reg;
  assign o_port_change_status = pst_reg;
  assign o_timer_a_preload = ta_reg;
  assign o_timer_b_preload = tb_reg;
  assign o_p01_out = ser.pin;
  assign o_p01_oe = ser.oe;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  chk_hold_en_load: assert property (go && i_instr[15:8] == 8'h41 |=> hold_reg == $past(imm)) // see [RULE1]
    else $error("hold release flags not loaded");
  chk_p1_en_load: assert property (go && i_instr[15:4] == 12'h330 |=> p1_reg == $past(imm[3:2])) // see [RULE5]
    else $error("port1 enable flags wrong");
  chk_ev_clear: assert property (go && i_instr[15:8] == 8'h40 && i_event_set == 8'h00 // see [RULE7]
    |=> ev_reg == ($past(ev_reg) & ~$past(imm)))
    else $error("event latch clear wrong");
  chk_ev_set_wins: assert property (i_event_set[0] |=> ev_reg[0]) // see [RULE7]
    else $error("event lost during clear");
  chk_pst1_clear: assert property (go && i_instr == 16'h4280 && i_port_change_set == 12'h000 // see [RULE9]
    |=> pst_reg[7:4] == 4'h0 && pst_reg[3:0] == $past(pst_reg[3:0]))
    else $error("port status 1 clear wrong");
  chk_div_pulse: assert property (go && i_instr == 16'h1700 ##1 !(go && i_instr == 16'h1700) // see [RULE10]
    |-> o_main_div_clr ##1 !o_main_div_clr)
    else $error("main divider clear not one pulse");
  chk_rrc_result: assert property (go && i_instr[15:7] == 9'h09B // see [RULE12]
    |=> o_acc_data == {$past(i_carry), $past(i_ram_nibble[3:1])} && o_carry == $past(i_ram_nibble[0])
        && o_acc_we && o_ram_we)
    else $error("rotate right through carry wrong");
  chk_shl_result: assert property (go && i_instr[15:7] == 9'h098 // see [RULE15]
    |=> o_ram_data == {$past(i_ram_nibble[2:0]), 1'b0} && o_carry == $past(i_ram_nibble[3]))
    else $error("shift left wrong");
  chk_lcd_write: assert property (go && i_instr[15:7] == 9'h134 // see [RULE16]
    |=> o_lcd_we && o_lcd_addr == {$past(lph_reg), $past(lpl_reg)})
    else $error("lcd indirect write address wrong");
  chk_gie_gate: assert property (go && i_instr == 16'h5080 |=> !o_gie) // see [RULE20]
    else $error("interrupt gate not closed");
  chk_avs_answer: assert property ($rose(i_avs_read) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("avalon answer later than one wait cycle");
endmodule

// *** test/nfd_seq_model.sv ***
// program sequencer model that feeds fetched words to the decoder
`timescale 1ns/1ns
module nfd_seq_model (
  input wire logic i_clk_sys,
  output logic o_valid = 1'b0,
  output logic [15:0] o_instr = 16'h0000,
  output logic [3:0] o_ram = 4'h0,
  output logic [3:0] o_acc = 4'h0,
  output logic o_carry = 1'b0
);
  // one word every second cycle, held only over its taking edge
  task automatic issue(input logic [15:0] w, input logic [3:0] r, input logic [3:0] a,
                       input logic c);
    @(posedge i_clk_sys);
    o_valid <= 1'b1;
    o_instr <= w;
    o_ram <= r;
    o_acc <= a;
    o_carry <= c;
    @(posedge i_clk_sys);
    o_valid <= 1'b0;
    // stale word inverted so a late sample cannot look right
    o_instr <= ~w;
  endtask
endmodule

// *** test/tb.sv ***
// self-checking bench for the peripheral and flag decoder
`timescale 1ns/1ns
module tb;
  logic i_clk_sys = 1'b0, i_rst = 1'b1, i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic i_instr_valid, i_carry, o_avs_waitrequest, o_acc_we, o_ram_we, o_carry_we, o_carry;
  logic o_zero, o_main_div_clr, o_sub_div_clr, o_wdt_clr, o_p01_out, o_p01_oe;
  logic [3:0] i_avs_address = 4'h0, i_ram_nibble, i_acc, o_acc_data;
  logic [7:0] i_event_set = 8'h00, o_hold_release_enable, o_event_latch;
  logic [15:0] i_instr;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, q;
  int err_count = 0, num_checks = 0, cycles = 0;
  nfd_seq_model u_seq (.i_clk_sys, .o_valid(i_instr_valid), .o_instr(i_instr),
    .o_ram(i_ram_nibble), .o_acc(i_acc), .o_carry(i_carry));
  nfd_top u_dut (.i_clk_sys, .i_rst, .i_instr_valid, .i_instr, .i_ram_nibble, .i_acc, .i_carry,
    .i_event_set, .i_rd_event_set(1'b0), .i_port_change_set(12'h000), .i_timer_a_value(8'h00),
    .i_timer_b_value(8'h00), .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable(4'hF), .o_avs_readdata, .o_avs_waitrequest, .o_acc_we, .o_acc_data,
    .o_ram_we, .o_ram_data(), .o_carry_we, .o_carry, .o_zero_we(), .o_zero, .o_lcd_we(),
    .o_lcd_addr(), .o_lcd_data(), .o_main_div_clr, .o_sub_div_clr, .o_wdt_clr, .o_hold_req(),
    .o_stop_req(), .o_gie(), .o_hold_release_enable, .o_rd_hold_release_enable(),
    .o_irq_source_enable(), .o_port_change_enable(), .o_port1_pin_enable(),
    .o_stop_wake_enable(), .o_event_latch, .o_rd_event_latch(), .o_port_change_status(),
    .o_timer_a_preload(), .o_timer_b_preload(), .o_p01_out, .o_p01_oe);
  always #25 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  // waitrequest is looked at on each falling edge; release after the rising edge where it is low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_avs_read <= ~w;
    i_avs_write <= w;
    i_avs_address <= a;
    i_avs_writedata <= d;
    do @(negedge i_clk_sys); while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata;
    @(posedge i_clk_sys);
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask
  task automatic t_shift;
    logic [15:0] op[4] = '{nfd_pkg::OP_SHR, nfd_pkg::OP_RRC, nfd_pkg::OP_SHL, nfd_pkg::OP_RLC};
    logic [3:0] ex[4] = '{4'h4, 4'hC, 4'h2, 4'h3};
    for (int i = 0; i < 4; i++) begin
      u_seq.issue(op[i] | 16'h0012, 4'h9, 4'h0, 1'b1);
      #1;
      chk("shift", {3'h7, ex[i], 2'b10}, {o_acc_we, o_ram_we, o_carry_we, o_acc_data, o_carry, o_zero});
    end
  endtask
  task automatic t_flags;
    u_seq.issue(nfd_pkg::OP_HOLD_EN | 16'h00A5, 4'h0, 4'h0, 1'b0);
    u_seq.issue(nfd_pkg::OP_IRQ_EN | 16'h003C, 4'h0, 4'h0, 1'b0);
    bus(1'b0, nfd_pkg::REG_ENABLES, 32'h0);
    chk("enables", 32'h00003CA5, q);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'b1, nfd_pkg::REG_CTRL, 32'h0);
    u_seq.issue(nfd_pkg::OP_HOLD_EN | 16'h00FF, 4'h0, 4'h0, 1'b0);
    #1;
    chk("refused", 32'hA5, o_hold_release_enable);
    bus(1'b1, nfd_pkg::REG_CTRL, 32'h1);
  endtask
  task automatic t_events;
    @(posedge i_clk_sys);
    i_event_set <= 8'hFF;
    @(posedge i_clk_sys);
    i_event_set <= 8'h00;
    u_seq.issue(nfd_pkg::OP_EV_CLR | 16'h005A, 4'h0, 4'h0, 1'b0);
    #1;
    chk("ev clear", 32'hA5, o_event_latch);
    u_seq.issue(nfd_pkg::OP_EV_HI, 4'h0, 4'h0, 1'b0);
    #1;
    chk("ev high", 32'h1A, {o_acc_we, o_acc_data});
  endtask
  task automatic t_pulses;
    logic [15:0] op[3] = '{nfd_pkg::OP_MDIV_CLR, nfd_pkg::OP_SDIV_CLR, nfd_pkg::OP_WDT_CLR};
    for (int i = 0; i < 3; i++) begin
      u_seq.issue(op[i], 4'h0, 4'h0, 1'b0);
      #1;
      chk("clear pulse", 32'h4 >> i, {o_main_div_clr, o_sub_div_clr, o_wdt_clr});
      @(posedge i_clk_sys);
      #1;
      chk("pulse end", 32'h0, {o_main_div_clr, o_sub_div_clr, o_wdt_clr});
    end
  endtask
  task automatic t_serial;
    u_seq.issue(nfd_pkg::OP_SER_OUT, 4'hA, 4'h5, 1'b0);
    #1;
    chk("serial bit7", 32'h3, {o_p01_oe, o_p01_out});
    repeat (20) @(posedge i_clk_sys);
    #1;
    chk("serial bit6", 32'h2, {o_p01_oe, o_p01_out});
  endtask
  initial begin
    repeat (12) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    t_shift();
    t_flags();
    t_events();
    t_pulses();
    t_serial();
    report_and_stop();
  end
endmodule
